// [rtl/pev_pkg.sv]
// constants and types for the performance event bus encoder
package pev_pkg;
   // ==========================================
   // bus geometry
   localparam int BUS_W = 210;
   localparam int W2 = 2;
   localparam int W3 = 3;
   localparam int W5 = 5;
   localparam int EXC_N = 13;
   // ==========================================
   // slice positions on the event bus
   localparam int RD_LSB = 128;
   localparam int WR_LSB = 130;
   localparam int UALD_LSB = 132;
   localparam int UAST_LSB = 134;
   localparam int UAANY_LSB = 136;
   localparam int LDX_BIT = 139;
   localparam int STXOK_BIT = 140;
   localparam int STXNOK_BIT = 141;
   localparam int STXANY_BIT = 142;
   localparam int LDOP_LSB = 143;
   localparam int STOP_LSB = 148;
   localparam int INTOP_LSB = 153;
   localparam int VEC_LSB = 158;
   localparam int FLT_LSB = 163;
   localparam int PCW_LSB = 168;
   localparam int CIPH_LSB = 170;
   localparam int BRIMM_LSB = 175;
   localparam int BRRET_LSB = 177;
   localparam int BRIND_LSB = 179;
   localparam int ISB_BIT = 181;
   localparam int DSB_LSB = 182;
   localparam int DMB_LSB = 184;
   localparam int EXC_LSB = 186;
   localparam int ACQ_LSB = 199;
   localparam int REL_LSB = 204;
   localparam int L3RD_BIT = 209;
   // ==========================================
   // positions inside the exception field
   localparam int EX_UNDEF = 0;
   localparam int EX_SVC = 1;
   localparam int EX_IABT = 2;
   localparam int EX_DABT = 3;
   localparam int EX_IRQ = 4;
   localparam int EX_FIQ = 5;
   localparam int EX_SMC = 6;
   localparam int EX_HVC = 7;
   localparam int EX_T_IABT = 8;
   localparam int EX_T_DABT = 9;
   localparam int EX_T_OTHER = 10;
   localparam int EX_T_IRQ = 11;
   localparam int EX_T_FIQ = 12;
   // ==========================================
   // reporting lanes per cycle
   localparam int MEM_LANES = 2;
   localparam int UA_LANES = 2;
   localparam int SPEC_LANES = 8;
   localparam int BR_LANES = 3;
   localparam logic [BUS_W-1:0] BUS_RST = '0;
   // ==========================================
   // origin of a data-side memory access
   typedef enum logic [2:0] {
      PEV_KIND_DEMAND,
      PEV_KIND_IFETCH,
      PEV_KIND_CMO,
      PEV_KIND_WALK,
      PEV_KIND_PREFETCH
   } pev_kind_t;
   // exception classes reported by the core
   typedef enum logic [3:0] {
      PEV_UNDEFINED_EXCEPTION_EVENT,
      PEV_SUPERVISOR_CALL_EVENT,
      PEV_EXC_IABT,
      PEV_EXC_DABT,
      PEV_NORMAL_IRQ_LOCAL_EVENT,
      PEV_FAST_IRQ_LOCAL_EVENT,
      PEV_SECURE_MONITOR_CALL_EVENT,
      PEV_HYPERVISOR_CALL_EVENT,
      PEV_EXC_OTHER
   } pev_exc_t;
endpackage : pev_pkg

// [rtl/pev_lane_count.sv]
// counts the active lanes of one event group in the current cycle
`timescale 1ns/1ps
module pev_lane_count #(
   parameter int LANES = 8,
   parameter int CW = 5
) (
   // lanes reporting the event
   input wire logic [LANES-1:0] lanes_in,
   // binary count of active lanes
   output logic [CW-1:0] count_out
);
   // ==========================================
   // population count
   function automatic logic [CW-1:0] ones(input logic [LANES-1:0] v);
      logic [CW-1:0] n;
      n = '0;
      for (int i = 0; i < LANES; i++) begin
         n = n + CW'(v[i]);
      end
      return n;
   endfunction : ones

   // lane counts are sized so the slice never overflows
   always_comb begin
      count_out = ones(lanes_in);
   end
endmodule : pev_lane_count

// [rtl/pev_exc_decode.sv]
// turns one taken exception into its one-hot event field
`timescale 1ns/1ps
module pev_exc_decode (
   // exception report
   input wire logic taken_in,
   input wire pev_pkg::pev_exc_t class_in,
   input wire logic local_in,
   // one bit per exception event
   output logic [pev_pkg::EXC_N-1:0] onehot_out
);
   // ==========================================
   // class and level to event position
   always_comb begin
      onehot_out = '0;
      if (taken_in && local_in) begin
         unique case (class_in)
            pev_pkg::PEV_UNDEFINED_EXCEPTION_EVENT: onehot_out[pev_pkg::EX_UNDEF] = 1'b1;
            pev_pkg::PEV_SUPERVISOR_CALL_EVENT: onehot_out[pev_pkg::EX_SVC] = 1'b1;
            pev_pkg::PEV_EXC_IABT: onehot_out[pev_pkg::EX_IABT] = 1'b1;
            pev_pkg::PEV_EXC_DABT: onehot_out[pev_pkg::EX_DABT] = 1'b1;
            pev_pkg::PEV_NORMAL_IRQ_LOCAL_EVENT: onehot_out[pev_pkg::EX_IRQ] = 1'b1;
            pev_pkg::PEV_FAST_IRQ_LOCAL_EVENT: onehot_out[pev_pkg::EX_FIQ] = 1'b1;
            pev_pkg::PEV_SECURE_MONITOR_CALL_EVENT: onehot_out[pev_pkg::EX_SMC] = 1'b1;
            pev_pkg::PEV_HYPERVISOR_CALL_EVENT: onehot_out[pev_pkg::EX_HVC] = 1'b1;
            default: onehot_out = '0; // local other has no event
         endcase
      end else if (taken_in) begin
         // calls and undefined trapped upward count as other traps
         unique case (class_in)
            pev_pkg::PEV_EXC_IABT: onehot_out[pev_pkg::EX_T_IABT] = 1'b1;
            pev_pkg::PEV_EXC_DABT: onehot_out[pev_pkg::EX_T_DABT] = 1'b1;
            pev_pkg::PEV_NORMAL_IRQ_LOCAL_EVENT: onehot_out[pev_pkg::EX_T_IRQ] = 1'b1;
            pev_pkg::PEV_FAST_IRQ_LOCAL_EVENT: onehot_out[pev_pkg::EX_T_FIQ] = 1'b1;
            default: onehot_out[pev_pkg::EX_T_OTHER] = 1'b1;
         endcase
      end
   end
endmodule : pev_exc_decode

// [rtl/pev_encoder.sv]
// per-cycle performance event bus encoder for the on-core trace unit
// Function
// - data read access slice counts memory accesses from load instructions.
// - fetches, cache maintenance, table walks and prefetches never count.
// - data write access slice counts memory accesses from store instructions.
// - exclusive load, store pass, store fail and any store on own bits.
// - speculative loads, stores and integer ops counted on five-bit slices.
// - speculative vector, float and cipher ops counted on five-bit slices.
// - speculative program counter writes counted on a two-bit slice.
// - immediate, return and indirect branches each on a two-bit slice.
// - instruction sync barrier one bit; data sync and memory barrier two.
// - undefined and supervisor call exceptions taken locally pulse once.
// - local instruction abort and data abort or system error pulse.
// - local normal and fast interrupts pulse each time taken.
// - local secure monitor and hypervisor calls pulse when taken.
// - exceptions taken at a non-local level pulse their own five bits.
// - load-acquire and store-release counted on five-bit slices.
// - constant cycle and backend stall events stay off the bus.
// - long-latency cache miss events stay off the bus.
// - bus goes only to the on-core trace unit, same clock.
`timescale 1ns/1ps
module pev_encoder (
   // clock and reset
   input wire logic mclk_in,
   input wire logic arst_n_in,
   // data memory accesses, one kind per lane
   input wire logic [1:0] mem_rd_valid_in,
   input wire pev_pkg::pev_kind_t [1:0] mem_rd_kind_in,
   input wire logic [1:0] mem_wr_valid_in,
   input wire pev_pkg::pev_kind_t [1:0] mem_wr_kind_in,
   input wire logic [1:0] unaligned_ld_in,
   input wire logic [1:0] unaligned_st_in,
   // exclusive operations
   input wire logic load_exclusive_spec_event_in,
   input wire logic store_exclusive_ok_event_in,
   input wire logic store_exclusive_nok_event_in,
   // speculative operation lanes
   input wire logic [7:0] load_op_spec_event_in,
   input wire logic [7:0] store_op_spec_event_in,
   input wire logic [7:0] integer_op_spec_event_in,
   input wire logic [7:0] vector_op_spec_event_in,
   input wire logic [7:0] float_op_spec_event_in,
   input wire logic [2:0] program_counter_write_event_in,
   input wire logic [7:0] cipher_op_spec_event_in,
   // branches and barriers
   input wire logic [2:0] immediate_branch_event_in,
   input wire logic [2:0] return_branch_event_in,
   input wire logic [2:0] indirect_branch_event_in,
   input wire logic instr_sync_barrier_event_in,
   input wire logic [2:0] data_sync_barrier_event_in,
   input wire logic [2:0] data_mem_barrier_event_in,
   // exception taken this cycle
   input wire logic exc_taken_in,
   input wire pev_pkg::pev_exc_t exc_class_in,
   input wire logic exc_local_in,
   // ordering operations and level-3 reads
   input wire logic [7:0] load_acquire_spec_event_in,
   input wire logic [7:0] store_release_spec_event_in,
   input wire logic l3_read_in,
   // events that have no bus slice
   input wire logic constant_freq_cycle_event_in,
   input wire logic backend_mem_stall_event_in,
   input wire logic level1_instr_slow_miss_event_in,
   input wire logic level2_slow_miss_event_in,
   input wire logic level3_slow_miss_event_in,
   // event bus to the trace unit
   output logic [pev_pkg::BUS_W-1:0] perf_event_trace_bus_out,
   // off-bus events for the local counters
   output logic constant_freq_cycle_event_out,
   output logic backend_mem_stall_event_out,
   output logic level1_instr_slow_miss_event_out,
   output logic level2_slow_miss_event_out,
   output logic level3_slow_miss_event_out
);
   // ==========================================
   // access origin filter
   // only demand accesses from load or store instructions are counted
   function automatic logic [1:0] demand_only(
      input logic [1:0] valid,
      input pev_pkg::pev_kind_t [1:0] kind
   );
      logic [1:0] m;
      m = '0;
      for (int i = 0; i < pev_pkg::MEM_LANES; i++) begin
         m[i] = valid[i] && (kind[i] == pev_pkg::PEV_KIND_DEMAND);
      end
      return m;
   endfunction : demand_only

   logic [1:0] rd_lanes;
   logic [1:0] wr_lanes;
   always_comb begin
      rd_lanes = demand_only(mem_rd_valid_in, mem_rd_kind_in);
      wr_lanes = demand_only(mem_wr_valid_in, mem_wr_kind_in);
   end

   // ==========================================
   // lane counters
   logic [1:0] rd_cnt;
   logic [1:0] wr_cnt;
   logic [1:0] uald_cnt;
   logic [1:0] uast_cnt;
   logic [2:0] uaany_cnt;
   logic [4:0] ld_cnt;
   logic [4:0] st_cnt;
   logic [4:0] int_cnt;
   logic [4:0] vec_cnt;
   logic [4:0] flt_cnt;
   logic [1:0] pcw_cnt;
   logic [4:0] ciph_cnt;
   logic [1:0] brimm_cnt;
   logic [1:0] brret_cnt;
   logic [1:0] brind_cnt;
   logic [1:0] dsb_cnt;
   logic [1:0] dmb_cnt;
   logic [4:0] acq_cnt;
   logic [4:0] rel_cnt;
   logic [pev_pkg::EXC_N-1:0] exc_hot;

   pev_lane_count #(.LANES(2), .CW(2)) u_rd (
      .lanes_in(rd_lanes), .count_out(rd_cnt));
   pev_lane_count #(.LANES(2), .CW(2)) u_wr (
      .lanes_in(wr_lanes), .count_out(wr_cnt));
   pev_lane_count #(.LANES(2), .CW(2)) u_uald (
      .lanes_in(unaligned_ld_in), .count_out(uald_cnt));
   pev_lane_count #(.LANES(2), .CW(2)) u_uast (
      .lanes_in(unaligned_st_in), .count_out(uast_cnt));
   // each direction of an unaligned access counts once per lane
   pev_lane_count #(.LANES(4), .CW(3)) u_uaany (
      .lanes_in({unaligned_st_in, unaligned_ld_in}),
      .count_out(uaany_cnt));
   pev_lane_count #(.LANES(8), .CW(5)) u_ld (
      .lanes_in(load_op_spec_event_in), .count_out(ld_cnt));
   pev_lane_count #(.LANES(8), .CW(5)) u_st (
      .lanes_in(store_op_spec_event_in), .count_out(st_cnt));
   pev_lane_count #(.LANES(8), .CW(5)) u_int (
      .lanes_in(integer_op_spec_event_in), .count_out(int_cnt));
   pev_lane_count #(.LANES(8), .CW(5)) u_vec (
      .lanes_in(vector_op_spec_event_in), .count_out(vec_cnt));
   pev_lane_count #(.LANES(8), .CW(5)) u_flt (
      .lanes_in(float_op_spec_event_in), .count_out(flt_cnt));
   pev_lane_count #(.LANES(3), .CW(2)) u_pcw (
      .lanes_in(program_counter_write_event_in),
      .count_out(pcw_cnt));
   pev_lane_count #(.LANES(8), .CW(5)) u_ciph (
      .lanes_in(cipher_op_spec_event_in), .count_out(ciph_cnt));
   pev_lane_count #(.LANES(3), .CW(2)) u_brimm (
      .lanes_in(immediate_branch_event_in), .count_out(brimm_cnt));
   pev_lane_count #(.LANES(3), .CW(2)) u_brret (
      .lanes_in(return_branch_event_in), .count_out(brret_cnt));
   pev_lane_count #(.LANES(3), .CW(2)) u_brind (
      .lanes_in(indirect_branch_event_in), .count_out(brind_cnt));
   pev_lane_count #(.LANES(3), .CW(2)) u_dsb (
      .lanes_in(data_sync_barrier_event_in), .count_out(dsb_cnt));
   pev_lane_count #(.LANES(3), .CW(2)) u_dmb (
      .lanes_in(data_mem_barrier_event_in), .count_out(dmb_cnt));
   pev_lane_count #(.LANES(8), .CW(5)) u_acq (
      .lanes_in(load_acquire_spec_event_in), .count_out(acq_cnt));
   pev_lane_count #(.LANES(8), .CW(5)) u_rel (
      .lanes_in(store_release_spec_event_in), .count_out(rel_cnt));

   // one exception at most per cycle, so the field is one-hot or zero
   pev_exc_decode u_exc (
      .taken_in(exc_taken_in),
      .class_in(exc_class_in),
      .local_in(exc_local_in),
      .onehot_out(exc_hot));

   // ==========================================
   // bus assembly
   logic [pev_pkg::BUS_W-1:0] bus_next;
   logic [pev_pkg::BUS_W-1:0] bus_reg;
   logic [4:0] side_next;
   logic [4:0] side_reg;

   // events below the excerpted range are not produced here and read zero
   always_comb begin
      bus_next = pev_pkg::BUS_RST;
      bus_next[pev_pkg::RD_LSB +: pev_pkg::W2] = rd_cnt;
      bus_next[pev_pkg::WR_LSB +: pev_pkg::W2] = wr_cnt;
      bus_next[pev_pkg::UALD_LSB +: pev_pkg::W2] = uald_cnt;
      bus_next[pev_pkg::UAST_LSB +: pev_pkg::W2] = uast_cnt;
      bus_next[pev_pkg::UAANY_LSB +: pev_pkg::W3] = uaany_cnt;
      bus_next[pev_pkg::LDX_BIT] = load_exclusive_spec_event_in;
      bus_next[pev_pkg::STXOK_BIT] = store_exclusive_ok_event_in;
      bus_next[pev_pkg::STXNOK_BIT] = store_exclusive_nok_event_in;
      bus_next[pev_pkg::STXANY_BIT] = store_exclusive_ok_event_in
         | store_exclusive_nok_event_in;
      bus_next[pev_pkg::LDOP_LSB +: pev_pkg::W5] = ld_cnt;
      bus_next[pev_pkg::STOP_LSB +: pev_pkg::W5] = st_cnt;
      bus_next[pev_pkg::INTOP_LSB +: pev_pkg::W5] = int_cnt;
      bus_next[pev_pkg::VEC_LSB +: pev_pkg::W5] = vec_cnt;
      bus_next[pev_pkg::FLT_LSB +: pev_pkg::W5] = flt_cnt;
      bus_next[pev_pkg::PCW_LSB +: pev_pkg::W2] = pcw_cnt;
      bus_next[pev_pkg::CIPH_LSB +: pev_pkg::W5] = ciph_cnt;
      bus_next[pev_pkg::BRIMM_LSB +: pev_pkg::W2] = brimm_cnt;
      bus_next[pev_pkg::BRRET_LSB +: pev_pkg::W2] = brret_cnt;
      bus_next[pev_pkg::BRIND_LSB +: pev_pkg::W2] = brind_cnt;
      bus_next[pev_pkg::ISB_BIT] = instr_sync_barrier_event_in;
      bus_next[pev_pkg::DSB_LSB +: pev_pkg::W2] = dsb_cnt;
      bus_next[pev_pkg::DMB_LSB +: pev_pkg::W2] = dmb_cnt;
      bus_next[pev_pkg::EXC_LSB +: pev_pkg::EXC_N] = exc_hot;
      bus_next[pev_pkg::ACQ_LSB +: pev_pkg::W5] = acq_cnt;
      bus_next[pev_pkg::REL_LSB +: pev_pkg::W5] = rel_cnt;
      bus_next[pev_pkg::L3RD_BIT] = l3_read_in;
      // these go to the local counters only, never onto the bus
      side_next = {level3_slow_miss_event_in,
                   level2_slow_miss_event_in,
                   level1_instr_slow_miss_event_in,
                   backend_mem_stall_event_in,
                   constant_freq_cycle_event_in};
   end

   // one register stage; every cycle is a fresh sample, no holding
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         bus_reg <= pev_pkg::BUS_RST;
         side_reg <= '0;
      end else begin
         bus_reg <= bus_next;
         side_reg <= side_next;
      end
   end

   // ==========================================
   // outputs
   // same clock as the trace unit: an async crossing would drop events
   assign perf_event_trace_bus_out = bus_reg;
   assign constant_freq_cycle_event_out = side_reg[0];
   assign backend_mem_stall_event_out = side_reg[1];
   assign level1_instr_slow_miss_event_out = side_reg[2];
   assign level2_slow_miss_event_out = side_reg[3];
   assign level3_slow_miss_event_out = side_reg[4];

   // ==========================================
   // assertions
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);

   property p_rd_count;
      (mem_rd_valid_in == 2'b11
         && mem_rd_kind_in[0] == pev_pkg::PEV_KIND_DEMAND
         && mem_rd_kind_in[1] == pev_pkg::PEV_KIND_DEMAND)
      |=> perf_event_trace_bus_out[129:128] == 2'd2;
   endproperty
   a_rd_count: assert property (p_rd_count)
      else $error("read access count wrong");

   property p_excluded;
      (mem_rd_kind_in[0] != pev_pkg::PEV_KIND_DEMAND
         && mem_rd_kind_in[1] != pev_pkg::PEV_KIND_DEMAND
         && mem_wr_kind_in[0] != pev_pkg::PEV_KIND_DEMAND
         && mem_wr_kind_in[1] != pev_pkg::PEV_KIND_DEMAND)
      |=> perf_event_trace_bus_out[131:128] == 4'h0;
   endproperty
   a_excluded: assert property (p_excluded)
      else $error("non-demand access was counted");

   property p_wr_count;
      (mem_wr_valid_in == 2'b01
         && mem_wr_kind_in[0] == pev_pkg::PEV_KIND_DEMAND)
      |=> perf_event_trace_bus_out[131:130] == 2'd1;
   endproperty
   a_wr_count: assert property (p_wr_count)
      else $error("write access count wrong");

   property p_strex_any;
      1'b1 |=> perf_event_trace_bus_out[142] ==
         ($past(store_exclusive_ok_event_in)
          || $past(store_exclusive_nok_event_in));
   endproperty
   a_strex_any: assert property (p_strex_any)
      else $error("store exclusive any mismatch");

   property p_load_ops;
      (load_op_spec_event_in == 8'hff)
      |=> perf_event_trace_bus_out[147:143] == 5'd8;
   endproperty
   a_load_ops: assert property (p_load_ops)
      else $error("load op count wrong");

   property p_cipher;
      (cipher_op_spec_event_in == 8'h0f)
      |=> perf_event_trace_bus_out[174:170] == 5'd4;
   endproperty
   a_cipher: assert property (p_cipher)
      else $error("cipher op count wrong");

   property p_pc_write;
      (program_counter_write_event_in == 3'b101)
      |=> perf_event_trace_bus_out[169:168] == 2'd2;
   endproperty
   a_pc_write: assert property (p_pc_write)
      else $error("pc write count wrong");

   property p_indirect;
      (indirect_branch_event_in == 3'b111)
      |=> perf_event_trace_bus_out[180:179] == 2'd3;
   endproperty
   a_indirect: assert property (p_indirect)
      else $error("indirect branch count wrong");

   property p_barrier;
      (instr_sync_barrier_event_in && data_mem_barrier_event_in == 3'b011)
      |=> perf_event_trace_bus_out[181]
          && perf_event_trace_bus_out[185:184] == 2'd2;
   endproperty
   a_barrier: assert property (p_barrier)
      else $error("barrier events wrong");

   property p_svc_local;
      (exc_taken_in && exc_local_in
         && exc_class_in == pev_pkg::PEV_SUPERVISOR_CALL_EVENT)
      |=> perf_event_trace_bus_out[187]
          && $onehot(perf_event_trace_bus_out[198:186]);
   endproperty
   a_svc_local: assert property (p_svc_local)
      else $error("supervisor call pulse wrong");

   property p_dabt_local;
      (exc_taken_in && exc_local_in
         && exc_class_in == pev_pkg::PEV_EXC_DABT)
      |=> perf_event_trace_bus_out[189] ##1 !perf_event_trace_bus_out[189]
          || $past(exc_taken_in);
   endproperty
   a_dabt_local: assert property (p_dabt_local)
      else $error("data abort pulse wrong");

   property p_fiq_local;
      (exc_taken_in && exc_local_in
         && exc_class_in == pev_pkg::PEV_FAST_IRQ_LOCAL_EVENT)
      |=> perf_event_trace_bus_out[191] && !perf_event_trace_bus_out[190];
   endproperty
   a_fiq_local: assert property (p_fiq_local)
      else $error("fast interrupt pulse wrong");

   property p_hvc_local;
      (exc_taken_in && exc_local_in
         && exc_class_in == pev_pkg::PEV_HYPERVISOR_CALL_EVENT)
      |=> perf_event_trace_bus_out[193];
   endproperty
   a_hvc_local: assert property (p_hvc_local)
      else $error("hypervisor call pulse wrong");

   property p_irq_trap;
      (exc_taken_in && !exc_local_in
         && exc_class_in == pev_pkg::PEV_NORMAL_IRQ_LOCAL_EVENT)
      |=> perf_event_trace_bus_out[197]
          && perf_event_trace_bus_out[193:186] == 8'h00;
   endproperty
   a_irq_trap: assert property (p_irq_trap)
      else $error("trapped interrupt pulse wrong");

   property p_release;
      (store_release_spec_event_in == 8'h81)
      |=> perf_event_trace_bus_out[208:204] == 5'd2;
   endproperty
   a_release: assert property (p_release)
      else $error("store release count wrong");

   property p_cycles_off_bus;
      constant_freq_cycle_event_in
      |=> constant_freq_cycle_event_out
          && perf_event_trace_bus_out[127:0] == 128'h0;
   endproperty
   a_cycles_off_bus: assert property (p_cycles_off_bus)
      else $error("constant cycle event misrouted");

   property p_miss_off_bus;
      level1_instr_slow_miss_event_in |=> level1_instr_slow_miss_event_out;
   endproperty
   a_miss_off_bus: assert property (p_miss_off_bus)
      else $error("slow miss event misrouted");

   property p_no_exc;
      !exc_taken_in |=> perf_event_trace_bus_out[198:186] == 13'h0;
   endproperty
   a_no_exc: assert property (p_no_exc)
      else $error("exception pulse without exception");
endmodule : pev_encoder

// [verification/pev_trace_sink.sv]
// trace unit model that samples the event bus every core cycle
`timescale 1ns/1ps
module pev_trace_sink (
   // clock and reset
   input wire logic mclk_in,
   input wire logic arst_n_in,
   // event bus and the last sample taken
   input wire logic [209:0] bus_in,
   output logic [209:0] seen_out
);
   // same clock as the encoder, so no synchroniser is needed
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) seen_out <= '0;
      else seen_out <= bus_in;
   end
endmodule : pev_trace_sink

// [verification/pev_encoder_tb.sv]
// self-checking testbench for the performance event bus encoder
`timescale 1ns/1ps
module pev_encoder_tb;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [1:0] rdv, wrv, ual, uas;
   pev_pkg::pev_kind_t [1:0] rdk, wrk;
   logic ldx, sok, snok, isb, ext, exl, l3, c0, c1, c2, c3, c4;
   logic [7:0] ld, st, io, vo, fo, co, acq, rel;
   logic [2:0] pcw, bi, br, bn, dsb, dmb;
   pev_pkg::pev_exc_t exc;
   logic [209:0] bus, seen, exp;
   logic [4:0] offo;
   int mismatches, tests_run;
   // ==========================================
   // design and trace unit model
   pev_encoder i_pev_encoder (.mclk_in(mclk), .arst_n_in(arst_n),
      .mem_rd_valid_in(rdv), .mem_rd_kind_in(rdk), .mem_wr_valid_in(wrv),
      .mem_wr_kind_in(wrk), .unaligned_ld_in(ual), .unaligned_st_in(uas),
      .load_exclusive_spec_event_in(ldx), .store_exclusive_ok_event_in(sok),
      .store_exclusive_nok_event_in(snok), .load_op_spec_event_in(ld),
      .store_op_spec_event_in(st), .integer_op_spec_event_in(io),
      .vector_op_spec_event_in(vo), .float_op_spec_event_in(fo),
      .program_counter_write_event_in(pcw), .cipher_op_spec_event_in(co),
      .immediate_branch_event_in(bi), .return_branch_event_in(br),
      .indirect_branch_event_in(bn), .instr_sync_barrier_event_in(isb),
      .data_sync_barrier_event_in(dsb), .data_mem_barrier_event_in(dmb),
      .exc_taken_in(ext), .exc_class_in(exc), .exc_local_in(exl),
      .load_acquire_spec_event_in(acq), .store_release_spec_event_in(rel),
      .l3_read_in(l3), .constant_freq_cycle_event_in(c0),
      .backend_mem_stall_event_in(c1), .level1_instr_slow_miss_event_in(c2),
      .level2_slow_miss_event_in(c3), .level3_slow_miss_event_in(c4),
      .perf_event_trace_bus_out(bus),
      .constant_freq_cycle_event_out(offo[0]),
      .backend_mem_stall_event_out(offo[1]),
      .level1_instr_slow_miss_event_out(offo[2]),
      .level2_slow_miss_event_out(offo[3]),
      .level3_slow_miss_event_out(offo[4]));
   pev_trace_sink i_pev_trace_sink (.mclk_in(mclk), .arst_n_in(arst_n),
      .bus_in(bus), .seen_out(seen));
   // ==========================================
   // common tasks
   task automatic check(input logic [209:0] got, input logic [209:0] want);
      tests_run++;
      if (got !== want) begin
         mismatches++;
         $display("Error at %0t: bus %h expected %h", $time, got, want);
      end
   endtask : check
   task automatic clear();
      {rdv, wrv, ual, uas, ldx, sok, snok, isb, ext, exl, l3} <= '0;
      {c0, c1, c2, c3, c4, ld, st, io, vo, fo, co, acq, rel} <= '0;
      {pcw, bi, br, bn, dsb, dmb} <= '0;
      rdk <= {pev_pkg::PEV_KIND_DEMAND, pev_pkg::PEV_KIND_DEMAND};
      wrk <= {pev_pkg::PEV_KIND_DEMAND, pev_pkg::PEV_KIND_DEMAND};
      exc <= pev_pkg::PEV_UNDEFINED_EXCEPTION_EVENT;
      exp = '0;
   endtask : clear
   // one edge registers the inputs, the next lets the trace unit sample
   task automatic settle();
      repeat (2) @(posedge mclk);
      #1;
      check(seen, exp);
      @(posedge mclk);
      clear();
   endtask : settle
   // ==========================================
   // scenarios
   task automatic t_mem();
      @(posedge mclk);
      {rdv, wrv, ual, uas} <= 8'hfd;
      wrk <= {pev_pkg::PEV_KIND_CMO, pev_pkg::PEV_KIND_DEMAND};
      exp[pev_pkg::RD_LSB +: 11] = {3'h3, 2'h1, 2'h2, 2'h1, 2'h2};
      settle();
      @(posedge mclk);
      {rdv, wrv} <= 4'hf;
      rdk <= {pev_pkg::PEV_KIND_IFETCH, pev_pkg::PEV_KIND_PREFETCH};
      wrk <= {pev_pkg::PEV_KIND_WALK, pev_pkg::PEV_KIND_CMO};
      settle();
   endtask : t_mem
   task automatic t_ops();
      @(posedge mclk);
      {ld, st, io, vo, fo, co, acq, rel} <= '1;
      {pcw, bi, br, bn, dsb, dmb, ldx, sok, isb, l3} <= '1;
      exp[pev_pkg::LDX_BIT +: 4] = 4'hb;
      // load, store, integer, vector, float, pc write, cipher
      exp[pev_pkg::LDOP_LSB +: 32] = {5'h08, 2'h3, {5{5'h08}}};
      exp[pev_pkg::BRIMM_LSB +: 11] = {2'h3, 2'h3, 1'b1, 2'h3, 2'h3, 2'h3};
      exp[pev_pkg::ACQ_LSB +: 11] = {1'b1, 5'h08, 5'h08};
      settle();
   endtask : t_ops
   task automatic t_exc();
      int i, b;
      for (i = 0; i < 18; i++) begin
         @(posedge mclk);
         {ext, exl} <= {1'b1, i[0]};
         exc <= pev_pkg::pev_exc_t'(i / 2);
         b = (i / 2 == 2) ? 8 : (i / 2 == 3) ? 9 : (i / 2 == 4) ? 11 : 10;
         if (i / 2 == 5) b = 12;
         // local other class has no event of its own
         if (i[0]) b = (i / 2 < 8) ? i / 2 : 13;
         if (b < 13) exp[pev_pkg::EXC_LSB + b] = 1'b1;
         settle();
      end
   endtask : t_exc
   task automatic t_off();
      @(posedge mclk);
      {c0, c1, c2, c3, c4} <= '1;
      settle();
      // inputs were cleared at the last edge; one more edge empties them
      @(posedge mclk);
      #1;
      check({205'h0, offo}, 210'h0);
      @(posedge mclk);
      {c0, c1, c2, c3, c4} <= '1;
      repeat (2) @(posedge mclk);
      #1;
      check({205'h0, offo}, {205'h0, 5'h1f});
   endtask : t_off
   // ==========================================
   // closing and run control
   task automatic conclude();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   initial begin
      forever #2 mclk = ~mclk;
   end
   initial begin
      #20000;
      mismatches++;
      conclude();
   end
   initial begin
      mismatches = 0;
      tests_run = 0;
      clear();
      repeat (20) @(posedge mclk);
      arst_n <= 1'b1;
      t_mem();
      t_ops();
      t_exc();
      t_off();
      conclude();
   end
endmodule : pev_encoder_tb
